// ---- hdl/pwli_pin_wakeup.sv ----
`default_nettype none

// What this block does
// [RQ1] pins zero and one trigger on falling edge or low level, classic style
// [RQ2] pin one trigger select: 0 low level, 1 falling edge
// [RQ3] pin zero trigger select: 0 low level, 1 falling edge
// [RQ4] pin two is falling edge only, no level option
// [RQ5] enabled port pins fire on any logic change, either direction
// [RQ6] port change wake and interrupt act only in halt/stop mode
// [RQ7] halt/stop entry refused while an enabled external pin is low
// [RQ8] port0 wake enable bits 7..0 enable each port0 pin
// [RQ9] port1 wake enable bits 7..0 enable each port1 pin
// [RQ10] port2 wake enable has only bits 1 and 0
// [RQ11] port3 wake enable bits 7..0 enable each port3 pin
// [RQ12] hardware sets low-voltage flag; software clears by writing 7Fh
// [RQ13] pin two edge flag set on falling edge regardless of its enable
// [RQ14] pin two edge flag clears on service routine entry
// [RQ15] port change flag set on enabled pin change; writing 0 clears it
// [RQ16] flag register: write 0 clears a flag, write 1 has no effect
// [RQ17] pin one edge flag set on edge regardless of enable, cleared on entry
// [RQ18] pin zero edge flag set on edge regardless of enable, cleared on entry
// [RQ19] pin enables gate interrupt and wake; wake ignores global enable
// [RQ20] low-voltage request from detector, gated by its enable bit
// [RQ21] service needs global and source enables; wake alone just resumes
// [RQ22] a wake trigger must last over 128 clocks to become an interrupt; the code applies no minimum length to any request
// [RQ23] every pin passes a two-stage synchroniser before detection
// [RQ24] level mode request follows the synchronised low level directly
module pwli_pin_wakeup
  import pwli_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        wbCyc,
  input  wire logic        wbStb,
  input  wire logic        wbWe,
  input  wire logic [9:0]  wbAdr,
  input  wire logic [3:0]  wbSel,
  input  wire logic [31:0] wbDatW,
  output logic      [31:0] wbDatR,
  output logic             wbAck,
  input  wire logic        extPinZero,
  input  wire logic        extPinOne,
  input  wire logic        extPinTwo,
  input  wire logic [7:0]  port0Pins,
  input  wire logic [7:0]  port1Pins,
  input  wire logic [1:0]  port2Pins,
  input  wire logic [7:0]  port3Pins,
  input  wire logic        supplyVoltageDetector,
  input  wire logic        haltActive,
  input  wire logic        haltRequest,
  input  wire logic        vecAckPinZero,
  input  wire logic        vecAckPinOne,
  input  wire logic        vecAckPinTwo,
  output logic             haltGrant,
  output logic             haltRefused,
  output logic             wakeUp,
  output logic             irqPinZero,
  output logic             irqPinOne,
  output logic             irqPinTwo,
  output logic             irqPortChange,
  output logic             irqLowVolt
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  pwli_state_t cur_ff;
  pwli_state_t nxt_state;

  logic [SYNC_W-1:0] pinVec;
  logic [SYNC_W-1:0] fallVec;
  logic [SYNC_W-1:0] changeVec;
  logic [25:0]       portEnMask;
  logic [25:0]       portChange;
  logic              accept;
  logic              commit;
  logic [7:0]        regIdx;
  logic              wrTcon;
  logic              wrFlags;
  logic [7:0]        wrByte;
  logic              lvlZero;
  logic              lvlOne;
  logic              lvlTwo;
  logic              trigZero;
  logic              trigOne;
  logic              reqZero;
  logic              reqOne;
  logic              enZero;
  logic              enOne;
  logic              enTwo;
  logic              enGlobal;
  logic              portChangeSet;
  logic [7:0]        tconBase;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // set wins over clear
  function automatic logic flagNext(input logic flag, input logic setEv, input logic clrEv);
    flagNext = setEv | (flag & ~clrEv);
  endfunction

  function automatic logic [7:0] readReg(input logic [7:0] idx, input pwli_state_t s);
    logic [7:0] val;
    val = READ_ZERO;
    if (idx == IDX_TIMER_EXT_IRQ_CTRL) begin
      val = s.timerExtIrqCtrl;
    end else if (idx == IDX_MISC_IRQ_FLAGS) begin
      val[FLG_LOW_VOLT_BIT]    = s.lowVoltFlag;
      val[FLG_PIN_TWO_BIT]     = s.pinTwoEdgeFlag;
      val[FLG_PORT_CHANGE_BIT] = s.portChangeFlag;
    end else if (idx == IDX_PORT1_WAKE_ENABLE) begin
      val = s.port1WakeEnable;
    end else if (idx == IDX_PORT0_WAKE_ENABLE) begin
      val = s.port0WakeEnable;
    end else if (idx == IDX_PORT2_WAKE_ENABLE) begin
      val[1:0] = s.port2WakeEnable;
    end else if (idx == IDX_PORT3_WAKE_ENABLE) begin
      val = s.port3WakeEnable;
    end else if (idx == IDX_MAIN_IRQ_ENABLE) begin
      val = s.mainIrqEnable & IE_IMPL_MASK;
    end else if (idx == IDX_EXTRA_IRQ_ENABLE) begin
      val = s.extraIrqEnable;
    end
    readReg = val;
  endfunction

  // ---------------------------------------------------------------
  // pin synchroniser and edge detection
  // ---------------------------------------------------------------
  assign pinVec = {port3Pins, port2Pins, port1Pins, port0Pins,
                   extPinTwo, extPinOne, extPinZero};

  // detection looks only at stages two and three
  assign fallVec   = cur_ff.syncC & ~cur_ff.syncB;   // [RQ23]
  assign changeVec = cur_ff.syncC ^ cur_ff.syncB;    // [RQ5]

  assign portEnMask = {cur_ff.port3WakeEnable,                        // [RQ11]
                       cur_ff.port2WakeEnable & PORT2_IMPL_MASK,      // [RQ10]
                       cur_ff.port1WakeEnable,                        // [RQ9]
                       cur_ff.port0WakeEnable};                       // [RQ8]
  assign portChange = changeVec[SYNC_P3_HI:SYNC_P0_LO] & portEnMask;

  // change detection armed only in halt/stop
  assign portChangeSet = haltActive & (|portChange);                  // [RQ6] [RQ15]

  // ---------------------------------------------------------------
  // wishbone decode
  // ---------------------------------------------------------------
  assign regIdx  = wbAdr[9:2];
  assign accept  = wbCyc & wbStb & ~cur_ff.ack;
  assign commit  = wbCyc & wbStb & wbWe & cur_ff.ack & wbSel[0];
  assign wrByte  = wbDatW[7:0];
  assign wrTcon  = commit & (regIdx == IDX_TIMER_EXT_IRQ_CTRL);
  assign wrFlags = commit & (regIdx == IDX_MISC_IRQ_FLAGS);

  // ---------------------------------------------------------------
  // external pin requests
  // ---------------------------------------------------------------
  assign lvlZero  = ~cur_ff.syncB[0];
  assign lvlOne   = ~cur_ff.syncB[1];
  assign lvlTwo   = ~cur_ff.syncB[2];
  assign trigZero = cur_ff.timerExtIrqCtrl[TIMER_EXT_IRQ_CTRL_PIN_ZERO_TRIG_BIT];
  assign trigOne  = cur_ff.timerExtIrqCtrl[TIMER_EXT_IRQ_CTRL_PIN_ONE_TRIG_BIT];
  assign enZero   = cur_ff.mainIrqEnable[IE_PIN_ZERO_BIT];
  assign enOne    = cur_ff.mainIrqEnable[IE_PIN_ONE_BIT];
  assign enTwo    = cur_ff.extraIrqEnable[EXTRA_IRQ_ENABLE_PIN_TWO_BIT];
  assign enGlobal = cur_ff.mainIrqEnable[IE_GLOBAL_BIT];

  // level mode follows the pin, edge mode the latched flag
  assign reqZero = trigZero ? cur_ff.timerExtIrqCtrl[TIMER_EXT_IRQ_CTRL_PIN_ZERO_FLAG_BIT]
                            : lvlZero;                              // [RQ1] [RQ3] [RQ24]
  assign reqOne  = trigOne  ? cur_ff.timerExtIrqCtrl[TIMER_EXT_IRQ_CTRL_PIN_ONE_FLAG_BIT]
                            : lvlOne;                               // [RQ1] [RQ2] [RQ24]

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = cur_ff;
    tconBase  = cur_ff.timerExtIrqCtrl;

    nxt_state.syncA = pinVec;
    nxt_state.syncB = cur_ff.syncA;
    nxt_state.syncC = cur_ff.syncB;

    // bus answer one cycle after request
    nxt_state.ack = accept;
    if (accept) begin
      nxt_state.rdData = {24'h000000, readReg(regIdx, cur_ff)};
    end

    // plain enable registers
    if (commit) begin
      if (regIdx == IDX_PORT1_WAKE_ENABLE) begin
        nxt_state.port1WakeEnable = wrByte;
      end else if (regIdx == IDX_PORT0_WAKE_ENABLE) begin
        nxt_state.port0WakeEnable = wrByte;
      end else if (regIdx == IDX_PORT2_WAKE_ENABLE) begin
        nxt_state.port2WakeEnable = wrByte[1:0] & PORT2_IMPL_MASK;
      end else if (regIdx == IDX_PORT3_WAKE_ENABLE) begin
        nxt_state.port3WakeEnable = wrByte;
      end else if (regIdx == IDX_MAIN_IRQ_ENABLE) begin
        nxt_state.mainIrqEnable = wrByte & IE_IMPL_MASK;
      end else if (regIdx == IDX_EXTRA_IRQ_ENABLE) begin
        nxt_state.extraIrqEnable = wrByte;
      end
    end

    // control register, edge flags keep hardware set priority
    if (wrTcon) begin
      tconBase = wrByte;
    end
    nxt_state.timerExtIrqCtrl = tconBase;
    nxt_state.timerExtIrqCtrl[TIMER_EXT_IRQ_CTRL_PIN_ZERO_FLAG_BIT] =
      flagNext(tconBase[TIMER_EXT_IRQ_CTRL_PIN_ZERO_FLAG_BIT], fallVec[0], vecAckPinZero);  // [RQ18]
    nxt_state.timerExtIrqCtrl[TIMER_EXT_IRQ_CTRL_PIN_ONE_FLAG_BIT] =
      flagNext(tconBase[TIMER_EXT_IRQ_CTRL_PIN_ONE_FLAG_BIT], fallVec[1], vecAckPinOne);    // [RQ17]

    // flag register: zero clears, one leaves alone
    nxt_state.lowVoltFlag = flagNext(cur_ff.lowVoltFlag, supplyVoltageDetector,
      wrFlags & ~wrByte[FLG_LOW_VOLT_BIT]);                                   // [RQ12] [RQ16]
    nxt_state.pinTwoEdgeFlag = flagNext(cur_ff.pinTwoEdgeFlag, fallVec[2],
      vecAckPinTwo | (wrFlags & ~wrByte[FLG_PIN_TWO_BIT]));           // [RQ4] [RQ13] [RQ14]
    nxt_state.portChangeFlag = flagNext(cur_ff.portChangeFlag, portChangeSet,
      wrFlags & ~wrByte[FLG_PORT_CHANGE_BIT]);                                // [RQ15] [RQ16]
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cur_ff.syncA           <= SYNC_RESET;
      cur_ff.syncB           <= SYNC_RESET;
      cur_ff.syncC           <= SYNC_RESET;
      cur_ff.timerExtIrqCtrl <= REG_RESET;
      cur_ff.lowVoltFlag     <= 1'b0;
      cur_ff.pinTwoEdgeFlag  <= 1'b0;
      cur_ff.portChangeFlag  <= 1'b0;
      cur_ff.port0WakeEnable <= REG_RESET;
      cur_ff.port1WakeEnable <= REG_RESET;
      cur_ff.port2WakeEnable <= REG_RESET[1:0];
      cur_ff.port3WakeEnable <= REG_RESET;
      cur_ff.mainIrqEnable   <= REG_RESET;
      cur_ff.extraIrqEnable  <= REG_RESET;
      cur_ff.ack             <= 1'b0;
      cur_ff.rdData          <= 32'h00000000;
    end else begin
      cur_ff <= nxt_state;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign wbAck  = cur_ff.ack;
  assign wbDatR = cur_ff.rdData;

  // service needs global and source enable
  assign irqPinZero    = enGlobal & enZero & reqZero;                    // [RQ19] [RQ21]
  assign irqPinOne     = enGlobal & enOne & reqOne;                      // [RQ19] [RQ21]
  assign irqPinTwo     = enGlobal & enTwo & cur_ff.pinTwoEdgeFlag;       // [RQ19] [RQ21]
  assign irqPortChange = enGlobal & cur_ff.extraIrqEnable[EXTRA_IRQ_ENABLE_PORT_CHANGE_BIT]
                         & cur_ff.portChangeFlag & haltActive;           // [RQ6] [RQ21]
  assign irqLowVolt    = enGlobal & cur_ff.extraIrqEnable[EXTRA_IRQ_ENABLE_LOW_VOLT_BIT]
                         & cur_ff.lowVoltFlag;                           // [RQ20] [RQ21]

  // wake ignores the global enable
  assign wakeUp = (enZero & reqZero) | (enOne & reqOne)
                | (enTwo & cur_ff.pinTwoEdgeFlag)
                | (haltActive & cur_ff.portChangeFlag);                  // [RQ19] [RQ6]

  // enabled low pin blocks halt/stop entry
  assign haltRefused = (enZero & lvlZero) | (enOne & lvlOne) | (enTwo & lvlTwo);  // [RQ7]
  assign haltGrant   = haltRequest & ~haltRefused;                                // [RQ7]

endmodule
`default_nettype wire

// ---- hdl/pwli_pkg.sv ----
`default_nettype none
package pwli_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_TIMER_EXT_IRQ_CTRL = 8'h88;
  localparam logic [7:0] IDX_MISC_IRQ_FLAGS     = 8'h95;
  localparam logic [7:0] IDX_PORT1_WAKE_ENABLE  = 8'h96;
  localparam logic [7:0] IDX_PORT0_WAKE_ENABLE  = 8'h9C;
  localparam logic [7:0] IDX_PORT2_WAKE_ENABLE  = 8'h9D;
  localparam logic [7:0] IDX_PORT3_WAKE_ENABLE  = 8'h9E;
  localparam logic [7:0] IDX_MAIN_IRQ_ENABLE    = 8'hA8;
  localparam logic [7:0] IDX_EXTRA_IRQ_ENABLE   = 8'hA9;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int TIMER_EXT_IRQ_CTRL_PIN_ONE_FLAG_BIT  = 3;
  localparam int TIMER_EXT_IRQ_CTRL_PIN_ONE_TRIG_BIT  = 2;
  localparam int TIMER_EXT_IRQ_CTRL_PIN_ZERO_FLAG_BIT = 1;
  localparam int TIMER_EXT_IRQ_CTRL_PIN_ZERO_TRIG_BIT = 0;
  localparam int FLG_LOW_VOLT_BIT       = 7;
  localparam int FLG_PIN_TWO_BIT        = 2;
  localparam int FLG_PORT_CHANGE_BIT    = 1;
  localparam int IE_GLOBAL_BIT          = 7;
  localparam int IE_PIN_ONE_BIT         = 2;
  localparam int IE_PIN_ZERO_BIT        = 0;
  localparam int EXTRA_IRQ_ENABLE_LOW_VOLT_BIT     = 5;
  localparam int EXTRA_IRQ_ENABLE_PIN_TWO_BIT      = 2;
  localparam int EXTRA_IRQ_ENABLE_PORT_CHANGE_BIT  = 1;

  // implemented bits and reset values
  localparam logic [7:0] IE_IMPL_MASK    = 8'hBF;
  localparam logic [1:0] PORT2_IMPL_MASK = 2'h3;
  localparam logic [7:0] REG_RESET       = 8'h00;
  localparam logic [7:0] READ_ZERO       = 8'h00;

  // ---------------------------------------------------------------
  // synchronised pin vector layout
  // ---------------------------------------------------------------
  localparam int SYNC_W     = 29;
  localparam int SYNC_P0_LO = 3;
  localparam int SYNC_P0_HI = 10;
  localparam int SYNC_P1_LO = 11;
  localparam int SYNC_P1_HI = 18;
  localparam int SYNC_P2_LO = 19;
  localparam int SYNC_P2_HI = 20;
  localparam int SYNC_P3_LO = 21;
  localparam int SYNC_P3_HI = 28;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 29'h1FFFFFFF;

  typedef struct packed {
    logic [SYNC_W-1:0] syncA;
    logic [SYNC_W-1:0] syncB;
    logic [SYNC_W-1:0] syncC;
    logic [7:0]        timerExtIrqCtrl;
    logic              lowVoltFlag;
    logic              pinTwoEdgeFlag;
    logic              portChangeFlag;
    logic [7:0]        port0WakeEnable;
    logic [7:0]        port1WakeEnable;
    logic [1:0]        port2WakeEnable;
    logic [7:0]        port3WakeEnable;
    logic [7:0]        mainIrqEnable;
    logic [7:0]        extraIrqEnable;
    logic              ack;
    logic [31:0]       rdData;
  } pwli_state_t;

endpackage
`default_nettype wire

// ---- verification/pwli_cpu_seq.sv ----
`default_nettype none
module pwli_cpu_seq (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       serveOn,
  input  wire logic       slow,
  input  wire logic [2:0] irqIn,
  output logic      [2:0] vecAck
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] seenIrq;
  initial vecAck = 3'h0;
  // one vector pulse per request let through by the enables
  always @(posedge ref_clk) begin
    seenIrq <= irqIn;
    vecAck  <= (reset_n && serveOn) ? irqIn & ~vecAck & (slow ? seenIrq : 3'h7) : 3'h0;
  end
endmodule
`default_nettype wire

// ---- verification/pwli_pin_wakeup_sva.sv ----
`default_nettype none
module pwli_pin_wakeup_chk (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        wbCyc,
  input wire logic        wbStb,
  input wire logic        wbWe,
  input wire logic [31:0] wbDatR,
  input wire logic        wbAck,
  input wire logic        extPinZero,
  input wire logic        extPinOne,
  input wire logic        extPinTwo,
  input wire logic        haltActive,
  input wire logic        haltRequest,
  input wire logic        vecAckPinZero,
  input wire logic        vecAckPinTwo,
  input wire logic        haltGrant,
  input wire logic        haltRefused,
  input wire logic        wakeUp,
  input wire logic        irqPinZero,
  input wire logic        irqPinTwo,
  input wire logic        irqPortChange
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  a_ack_after_req: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
    else $error("no ack after request");
  a_ack_one_cycle: assert property (wbAck |=> !wbAck)
    else $error("ack longer than one cycle");
  a_read_upper_zero: assert property (wbAck |-> wbDatR[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_grant_by_refuse: assert property (haltGrant == (haltRequest && !haltRefused))
    else $error("grant disagrees with refusal");
  a_pins_high_accept: assert property
    ((extPinZero && extPinOne && extPinTwo) [*3] |=> !haltRefused)
    else $error("halt refused with all pins high");
  a_port_needs_halt: assert property (irqPortChange |-> haltActive)
    else $error("port change request outside halt");
  a_vec_clears_two: assert property
    (vecAckPinTwo && extPinTwo && $past(extPinTwo) && $past(extPinTwo, 2)
     && $past(extPinTwo, 3) |=> !irqPinTwo)
    else $error("pin two request kept after vector");
  a_vec_clears_zero: assert property
    (vecAckPinZero && !(wbCyc && wbStb && wbWe) && extPinZero && $past(extPinZero)
     && $past(extPinZero, 2) && $past(extPinZero, 3) |=> !irqPinZero)
    else $error("pin zero request kept after vector");
  a_reset_quiet: assert property
    ($rose(reset_n) |-> !wbAck && !haltRefused && !wakeUp && !irqPinTwo)
    else $error("outputs active after reset");
endmodule

bind pwli_pin_wakeup pwli_pin_wakeup_chk pwli_pin_wakeup_chk_inst (
  .ref_clk, .reset_n, .wbCyc, .wbStb, .wbWe, .wbDatR, .wbAck, .extPinZero,
  .extPinOne, .extPinTwo, .haltActive, .haltRequest, .vecAckPinZero,
  .vecAckPinTwo, .haltGrant, .haltRefused, .wakeUp, .irqPinZero, .irqPinTwo,
  .irqPortChange
);
`default_nettype wire

// ---- verification/tb.sv ----
`default_nettype none
module tb;
  import pwli_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, reset_n, wbCyc, wbStb, wbWe, wbAck, sv, haltActive;
  logic        haltRequest, serveOn, slow, haltGrant, haltRefused, wakeUp;
  logic        irqPinZero, irqPinOne, irqPinTwo, irqPortChange, irqLowVolt;
  logic [9:0]  wbAdr;
  logic [3:0]  wbSel;
  logic [31:0] wbDatW, wbDatR, rnd;
  logic [2:0]  ext, vecAck;
  logic [7:0]  p0, p1, p3, tr;
  logic [1:0]  p2;
  logic [31:0] expQ[$];
  string       nameQ[$];
  int          errCount, comparisons;
  int          ackCnt[3];
  logic [7:0]  regMap[9] = '{8'h88, 8'h95, 8'h96, 8'h9C, 8'h9D, 8'h9E, 8'hA8, 8'hA9, 8'h00};

  pwli_pin_wakeup pwli_pin_wakeup_inst (
    .ref_clk, .reset_n, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatW, .wbDatR,
    .wbAck, .extPinZero(ext[0]), .extPinOne(ext[1]), .extPinTwo(ext[2]),
    .port0Pins(p0), .port1Pins(p1), .port2Pins(p2), .port3Pins(p3),
    .supplyVoltageDetector(sv), .haltActive, .haltRequest,
    .vecAckPinZero(vecAck[0]), .vecAckPinOne(vecAck[1]), .vecAckPinTwo(vecAck[2]),
    .haltGrant, .haltRefused, .wakeUp, .irqPinZero, .irqPinOne, .irqPinTwo,
    .irqPortChange, .irqLowVolt
  );
  pwli_cpu_seq pwli_cpu_seq_inst (
    .ref_clk, .reset_n, .serveOn, .slow,
    .irqIn({irqPinTwo, irqPinOne, irqPinZero}), .vecAck
  );

  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] got);
    comparisons++;
    if (got !== e) begin
      errCount++;
      $display("ERROR %s expected %h seen %h", nm, e, got);
    end
  endtask
  task automatic testDone();
    $display("comparisons %0d mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    {wbCyc, wbStb, wbWe} <= {2'h3, we};
    wbAdr  <= {idx, 2'h0};
    wbDatW <= {24'h0, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (wbAck !== 1'h1 && n < 50);
    if (n >= 50) check("ack", 32'h1, 32'h0);
    {wbCyc, wbStb} <= 2'h0;
  endtask
  task automatic wr(input logic [7:0] i, d);
    bus(1'h1, i, d);
  endtask
  task automatic rd(input logic [7:0] i, e);
    expQ.push_back({24'h0, e});
    nameQ.push_back($sformatf("reg %h", i));
    bus(1'h0, i, 8'h00);
  endtask
  task automatic pulse(input int i);
    @(posedge ref_clk);
    ext[i] <= 1'h0;
    cyc(130);
    ext[i] <= 1'h1;
    cyc(6);
    @(negedge ref_clk);
  endtask

  // read results compared as they come back
  always @(negedge ref_clk) begin
    if (wbAck === 1'h1 && wbWe === 1'h0 && expQ.size() > 0) begin
      check(nameQ.pop_front(), expQ.pop_front(), wbDatR);
    end
  end
  always @(posedge ref_clk) begin
    for (int k = 0; k < 3; k++) begin
      if (vecAck[k] === 1'h1) ackCnt[k]++;
    end
  end
  initial begin
    cyc(20000);
    errCount++;
    testDone();
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    {wbCyc, wbStb, wbWe, wbAdr, wbDatW, sv, haltActive, haltRequest, serveOn, slow} = '0;
    {ext, p0, p1, p2, p3} = '1;
    wbSel = 4'hF;
    rnd = 32'h41FD208E;
    reset_n = 1'h0;
    cyc(5);
    reset_n <= 1'h1;
    foreach (regMap[k]) rd(regMap[k], 8'h00);
    rnd = lfsr(rnd);
    wr(8'h96, rnd[7:0]);
    rd(8'h96, rnd[7:0]);
    wr(8'h9C, rnd[15:8]);
    rd(8'h9C, rnd[15:8]);
    wr(8'h9D, 8'hFF);
    rd(8'h9D, 8'h03);
    wr(8'hA8, 8'hFF);
    rd(8'hA8, IE_IMPL_MASK);
    wr(8'h00, 8'hFF);
    rd(8'h00, 8'h00);
    $display("register access done");
    wr(8'hA8, 8'h00);
    pulse(2);
    check("irqPinTwo", 32'h0, irqPinTwo);
    rd(8'h95, 8'h04);
    wr(8'h95, 8'hFF);
    rd(8'h95, 8'h04);
    wr(8'h95, 8'hFB);
    rd(8'h95, 8'h00);
    wr(8'hA9, 8'h04);
    pulse(2);
    check("wakeUp", 32'h1, wakeUp);
    check("irqPinTwo", 32'h0, irqPinTwo);
    serveOn <= 1'h1;
    wr(8'hA8, 8'h80);
    cyc(4);
    rd(8'h95, 8'h00);
    ext[2] <= 1'h0;
    cyc(8);
    @(negedge ref_clk);
    check("irqPinTwo", 32'h0, irqPinTwo);
    check("ack2", 32'h2, ackCnt[2]);
    @(posedge ref_clk);
    ext[2] <= 1'h1;
    $display("pin two done");
    for (int i = 0; i < 2; i++) begin
      tr = 8'h01 << (2 * i);
      serveOn <= 1'h0;
      slow <= i[0];
      haltRequest <= 1'h1;
      wr(8'h88, 8'h00);
      wr(8'hA8, 8'h80 | tr);
      ext[i] <= 1'h0;
      cyc(6);
      @(negedge ref_clk);
      check("irqLevel", 32'h1, i ? irqPinOne : irqPinZero);
      check("haltGrant", 32'h0, haltGrant);
      @(posedge ref_clk);
      ext[i] <= 1'h1;
      cyc(6);
      @(negedge ref_clk);
      check("irqLevel", 32'h0, i ? irqPinOne : irqPinZero);
      check("haltGrant", 32'h1, haltGrant);
      rd(8'h88, tr << 1);
      wr(8'h88, tr);
      pulse(i);
      check("irqEdge", 32'h1, i ? irqPinOne : irqPinZero);
      serveOn <= 1'h1;
      cyc(6);
      rd(8'h88, tr);
      check("ackCnt", 32'h1, ackCnt[i]);
    end
    $display("pins zero and one done");
    haltRequest <= 1'h0;
    wr(8'hA9, 8'h02);
    wr(8'h9E, 8'h01);
    p3[0] <= 1'h0;
    cyc(6);
    rd(8'h95, 8'h00);
    haltActive <= 1'h1;
    p3[0] <= 1'h1;
    cyc(6);
    @(negedge ref_clk);
    check("irqPortChange", 32'h1, irqPortChange);
    rd(8'h95, 8'h02);
    wr(8'h95, 8'hFD);
    p3[1] <= 1'h0;
    cyc(6);
    rd(8'h95, 8'h00);
    haltActive <= 1'h0;
    $display("port change done");
    wr(8'hA9, 8'h20);
    sv <= 1'h1;
    cyc(2);
    sv <= 1'h0;
    cyc(3);
    @(negedge ref_clk);
    check("irqLowVolt", 32'h1, irqLowVolt);
    rd(8'h95, 8'h80);
    wr(8'h95, 8'h7F);
    rd(8'h95, 8'h00);
    $display("low voltage done");
    testDone();
  end
endmodule
`default_nettype wire
